/* File: design/analog_trim_register_bank.sv */
/*
 Trim register bank of the analog die: sleep reference trim and ADC
 offset compensation trim, reached over the die-to-die register port.
 Assumes a single clock domain, single-cycle request strobes and that
 the register content is held through low power by keeping the clock
 domain powered; only arst_n returns it to defaults.
*/
`timescale 1ns/100ps
module analog_trim_register_bank
    import trim_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_word,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_ack,
    output logic bus_write_refused,
    output logic [2:0] sleep_ref_trim_step,
    output logic sleep_ref_trim_active,
    output logic sleep_ref_trim_frozen,
    output logic signed [2:0] adc_offset_trim_step,
    output logic adc_offset_trim_active,
    output logic spare_trim_enable,
    output logic [2:0] spare_trim_code
);
    trim_if t();

    logic [7:0] sleep_reg_ff;
    logic [7:0] adc_reg_ff;
    logic [15:0] bus_rdata_ff;
    logic bus_ack_ff;
    logic refused_ff;
    logic [2:0] sleep_step_ff;
    logic sleep_active_ff;
    logic signed [2:0] adc_step_ff;
    logic adc_active_ff;
    logic spare_en_ff;
    logic [2:0] spare_code_ff;
    logic frozen_ff;

    logic frozen;
    logic hi_sleep;
    logic hi_adc;
    logic lo_sleep;
    logic lo_adc;
    logic [7:0] lo_addr;
    logic [7:0] nxt_sleep_reg;
    logic [7:0] nxt_adc_reg;
    logic [15:0] nxt_bus_rdata;
    logic nxt_refused;

    // Both bases map onto the same bank
    function automatic logic in_bank(input logic [15:0] addr);
        in_bank = (addr[15:8] == BLOCKING_BASE[15:8]) ||
                  (addr[15:8] == NONBLOCKING_BASE[15:8]);
    endfunction

    function automatic logic [7:0] read_byte(
        input logic [7:0] offset,
        input logic [7:0] sleep_val,
        input logic [7:0] adc_val
    );
        read_byte = READ_UNMAPPED;
        if (offset == SLEEP_TRIM_OFFSET) begin
            read_byte = sleep_val & SLEEP_WRITE_MASK;
        end else if (offset == ADC_TRIM_OFFSET) begin
            read_byte = adc_val;
        end
    endfunction

    // Frozen once enable and lock were both written one together
    assign frozen = sleep_reg_ff[SLEEP_ENABLE_POS] & sleep_reg_ff[SLEEP_LOCK_POS];

    // Word access: high byte at the addressed offset, even or odd, low byte at the offset above it
    assign lo_addr = bus_addr[7:0] + 8'h01;
    assign hi_sleep = in_bank(bus_addr) && bus_addr[7:0] == SLEEP_TRIM_OFFSET;
    assign hi_adc = in_bank(bus_addr) && bus_addr[7:0] == ADC_TRIM_OFFSET;
    assign lo_sleep = bus_word && in_bank(bus_addr) && lo_addr == SLEEP_TRIM_OFFSET;
    assign lo_adc = bus_word && in_bank(bus_addr) && lo_addr == ADC_TRIM_OFFSET;

    always_comb begin
        nxt_sleep_reg = sleep_reg_ff;
        nxt_refused = 1'b0;
        if (bus_wr && (hi_sleep || lo_sleep)) begin
            if (frozen) begin
                nxt_refused = 1'b1;
            end else if (hi_sleep) begin
                nxt_sleep_reg = (bus_word ? bus_wdata[15:8] : bus_wdata[7:0])
                                & SLEEP_WRITE_MASK;
            end else begin
                nxt_sleep_reg = bus_wdata[7:0] & SLEEP_WRITE_MASK;
            end
        end
    end

    always_comb begin
        nxt_adc_reg = adc_reg_ff;
        if (bus_wr && hi_adc) begin
            nxt_adc_reg = bus_word ? bus_wdata[15:8] : bus_wdata[7:0];
        end else if (bus_wr && lo_adc) begin
            nxt_adc_reg = bus_wdata[7:0];
        end
    end

    always_comb begin
        nxt_bus_rdata = {8'h00, READ_UNMAPPED};
        if (in_bank(bus_addr)) begin
            if (bus_word) begin
                nxt_bus_rdata = {read_byte(bus_addr[7:0], sleep_reg_ff, adc_reg_ff),
                                 read_byte(lo_addr, sleep_reg_ff, adc_reg_ff)};
            end else begin
                nxt_bus_rdata = {8'h00, read_byte(bus_addr[7:0], sleep_reg_ff, adc_reg_ff)};
            end
        end
    end

    // Only reset clears the bank; low power leaves the clock domain intact
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sleep_reg_ff <= SLEEP_TRIM_RESET;
            frozen_ff <= 1'b0;
        end else begin
            sleep_reg_ff <= nxt_sleep_reg;
            // Tracks the stored value so the flag shows together with the ack
            frozen_ff <= nxt_sleep_reg[SLEEP_ENABLE_POS]
                         & nxt_sleep_reg[SLEEP_LOCK_POS];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            adc_reg_ff <= ADC_TRIM_RESET;
        end else begin
            adc_reg_ff <= nxt_adc_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata_ff <= 16'h0000;
            bus_ack_ff <= 1'b0;
            refused_ff <= 1'b0;
        end else begin
            bus_ack_ff <= bus_wr | bus_rd;
            refused_ff <= nxt_refused;
            if (bus_rd) begin
                bus_rdata_ff <= nxt_bus_rdata;
            end
        end
    end

    assign t.sleep_reg = sleep_reg_ff;
    assign t.adc_reg = adc_reg_ff;

    trim_decoder u_decoder (
        .t(t)
    );

    // Applied trims registered so the analog side never sees decode glitches
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sleep_step_ff <= SLEEP_DEFAULT_STEP;
            sleep_active_ff <= 1'b0;
        end else begin
            sleep_step_ff <= t.sleep_step;
            sleep_active_ff <= t.sleep_apply;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            adc_step_ff <= ADC_ZERO_STEP;
            adc_active_ff <= 1'b0;
        end else begin
            adc_step_ff <= t.adc_step;
            adc_active_ff <= t.adc_apply;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            spare_en_ff <= 1'b0;
            spare_code_ff <= 3'h0;
        end else begin
            spare_en_ff <= adc_reg_ff[SPARE_ENABLE_POS];
            spare_code_ff <= adc_reg_ff[SPARE_CODE_LSB +: 3];
        end
    end

    assign bus_rdata = bus_rdata_ff;
    assign bus_ack = bus_ack_ff;
    assign bus_write_refused = refused_ff;
    assign sleep_ref_trim_step = sleep_step_ff;
    assign sleep_ref_trim_active = sleep_active_ff;
    assign sleep_ref_trim_frozen = frozen_ff;
    assign adc_offset_trim_step = adc_step_ff;
    assign adc_offset_trim_active = adc_active_ff;
    assign spare_trim_enable = spare_en_ff;
    assign spare_trim_code = spare_code_ff;
endmodule

/* File: design/trim_decoder.sv */
/*
 Combinational decode of the stored trim codes into applied trim steps.
 Assumes register contents arrive through trim_if; outputs are
 registered by the instantiating module.
*/
`timescale 1ns/100ps
module trim_decoder
    import trim_pkg::*;
(
    trim_if.decode t
);
    logic [2:0] sleep_code;
    logic [2:0] adc_code;

    assign sleep_code = t.sleep_reg[SLEEP_CODE_LSB +: 3];
    assign adc_code = t.adc_reg[ADC_CODE_LSB +: 3];

    always_comb begin
        // Both end codes land on the default step
        t.sleep_step = SLEEP_DEFAULT_STEP;
        t.sleep_apply = t.sleep_reg[SLEEP_ENABLE_POS];
        if (t.sleep_reg[SLEEP_ENABLE_POS] && sleep_code != 3'h7) begin
            t.sleep_step = sleep_code;
        end
    end

    always_comb begin
        t.adc_apply = t.adc_reg[ADC_ENABLE_POS];
        t.adc_step = ADC_ZERO_STEP;
        if (t.adc_reg[ADC_ENABLE_POS]) begin
            case (adc_code)
                3'h1: t.adc_step = 3'sh1;
                3'h2: t.adc_step = 3'sh2;
                3'h3: t.adc_step = 3'sh3;
                3'h4: t.adc_step = -3'sh3;
                3'h5: t.adc_step = -3'sh2;
                3'h6: t.adc_step = -3'sh1;
                default: t.adc_step = ADC_ZERO_STEP;
            endcase
        end
    end
endmodule

/* File: shared/trim_if.sv */
/*
 Carrier between the trim register store and the trim decoder.
 Assumes both ends run on the same clock; the bundle is combinational.
*/
`timescale 1ns/100ps
interface trim_if;
    logic [7:0] sleep_reg;
    logic [7:0] adc_reg;
    logic [2:0] sleep_step;
    logic sleep_apply;
    logic signed [2:0] adc_step;
    logic adc_apply;

    modport store (
        output sleep_reg,
        output adc_reg,
        input sleep_step,
        input sleep_apply,
        input adc_step,
        input adc_apply
    );
    modport decode (
        input sleep_reg,
        input adc_reg,
        output sleep_step,
        output sleep_apply,
        output adc_step,
        output adc_apply
    );
endinterface

/* File: shared/trim_pkg.sv */
/*
 Constants for the analog trim register bank: address bases, offsets,
 field positions, reset values and decode results.
 Assumes an 8-bit register data path and 16-bit global addresses.
*/
package trim_pkg;
    localparam logic [15:0] BLOCKING_BASE = 16'h0200;
    localparam logic [15:0] NONBLOCKING_BASE = 16'h0300;
    localparam logic [7:0] SLEEP_TRIM_OFFSET = 8'hF2;
    localparam logic [7:0] ADC_TRIM_OFFSET = 8'hF3;

    // Sleep reference trim register fields
    localparam int SLEEP_ENABLE_POS = 4;
    localparam int SLEEP_LOCK_POS = 3;
    localparam int SLEEP_CODE_LSB = 0;
    localparam logic [7:0] SLEEP_WRITE_MASK = 8'h1F;
    localparam logic [7:0] SLEEP_TRIM_RESET = 8'h00;

    // ADC offset trim register fields
    localparam int ADC_ENABLE_POS = 7;
    localparam int ADC_CODE_LSB = 4;
    localparam int SPARE_ENABLE_POS = 3;
    localparam int SPARE_CODE_LSB = 0;
    localparam logic [7:0] ADC_TRIM_RESET = 8'h00;

    // Decode results: step 0 is the default point of each trim
    localparam logic [2:0] SLEEP_DEFAULT_STEP = 3'h0;
    localparam logic signed [2:0] ADC_ZERO_STEP = 3'sh0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage

/* File: verification/host_model.sv */
/*
 Host initiator model: issues single register transfers to the bank.
 Assumes the bank answers one edge after each one-cycle request.
*/
`timescale 1ns/100ps
module host_model (
    input wire logic ref_clk,
    output logic bus_wr,
    output logic bus_rd,
    output logic bus_word,
    output logic [15:0] bus_addr,
    output logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_ack,
    input wire logic bus_write_refused
);
    initial begin
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_word = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 16'h0000;
    end
    task automatic xfer(input logic rd, input logic word, input logic [15:0] addr,
        input logic [15:0] data, output logic [15:0] rdata, output logic refused);
        @(posedge ref_clk);
        bus_rd <= rd;
        bus_wr <= !rd;
        bus_word <= word;
        bus_addr <= addr;
        bus_wdata <= data;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        bus_wr <= 1'b0;
        @(posedge ref_clk);
        rdata = bus_rdata;
        refused = bus_write_refused;
        // Released lines must not keep the last value
        bus_addr <= ~addr;
        bus_wdata <= ~data;
    endtask
endmodule

/* File: verification/tb.sv */
/*
 Self-checking bench for the trim register bank driven by the host model.
 Assumes the package constants and the one-cycle answer timing.
*/
`timescale 1ns/100ps
module tb
    import trim_pkg::*;
;
    logic ref_clk, arst_n, bus_wr, bus_rd, bus_word, bus_ack, bus_write_refused;
    logic [15:0] bus_addr, bus_wdata, bus_rdata, rdat;
    logic sleep_ref_trim_active, sleep_ref_trim_frozen, adc_offset_trim_active;
    logic spare_trim_enable, rd_d, refd;
    logic [2:0] sleep_ref_trim_step, spare_trim_code;
    logic signed [2:0] adc_offset_trim_step;
    logic [7:0] v;
    logic [15:0] exp_q[$];
    int error_cnt = 0;
    int n_checks = 0;
    int cycles = 0;
    analog_trim_register_bank analog_trim_register_bank_inst (.*);
    host_model host_model_inst (.*);
    always #4 ref_clk = ~ref_clk;
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [15:0] addr, input logic [15:0] data, input logic word);
        host_model_inst.xfer(1'b0, word, addr, data, rdat, refd);
        #1;
    endtask
    task automatic rd(input logic [15:0] addr, input logic word, input logic [15:0] exp);
        exp_q.push_back(exp);
        host_model_inst.xfer(1'b1, word, addr, 16'h0000, rdat, refd);
        #1;
    endtask
    function automatic logic [2:0] slp_exp(input logic [7:0] r);
        return (r[4] && r[2:0] != 3'h0 && r[2:0] != 3'h7) ? r[2:0] : 3'h0;
    endfunction
    function automatic logic [2:0] adc_exp(input logic [7:0] r);
        if (!r[7] || r[6:4] == 3'h0 || r[6:4] == 3'h7) return 3'h0;
        return r[6] ? r[6:4] + 3'h1 : r[6:4];
    endfunction
    always @(posedge ref_clk) begin
        if (rd_d && bus_ack === 1'b1) begin
            chk(bus_rdata, exp_q.pop_front());
        end
        rd_d <= bus_rd;
    end
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        ref_clk = 1'b0;
        arst_n = 1'b0;
        rd_d = 1'b0;
        void'($urandom(34120));
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(16'h02F2, 1'b0, 16'h0000);
        rd(16'h03F3, 1'b0, 16'h0000);
        $display("test reset_values done");
        for (int i = 0; i < 16; i++) begin
            v = {i[0], i[3:1], 4'($urandom)};
            wr({7'h01, i[1], ADC_TRIM_OFFSET}, {8'h00, v}, 1'b0);
            chk({13'h0000, adc_offset_trim_step}, adc_exp(v));
            chk(adc_offset_trim_active, v[7]);
            chk({spare_trim_enable, spare_trim_code}, v[3:0]);
            rd(16'h02F3, 1'b0, {8'h00, v});
        end
        $display("test adc_trim done");
        for (int i = 0; i < 16; i++) begin
            v = {3'h0, i[3], 1'b0, i[2:0]};
            wr(16'h02F2, {8'h00, v}, 1'b0);
            chk(sleep_ref_trim_step, slp_exp(v));
            chk(sleep_ref_trim_active, v[4]);
            chk(sleep_ref_trim_frozen, 1'b0);
        end
        wr(16'h02F2, 16'h000D, 1'b0);
        chk(sleep_ref_trim_frozen, 1'b0);
        rd(16'h02F2, 1'b0, 16'h000D);
        wr(16'h02F0, 16'h00FF, 1'b0);
        rd(16'h02F0, 1'b0, 16'h0000);
        $display("test sleep_search done");
        wr(16'h02F2, 16'h1B5A, 1'b1);
        chk(sleep_ref_trim_frozen, 1'b1);
        chk(sleep_ref_trim_step, 3'h3);
        wr(16'h02F2, 16'h0012, 1'b0);
        chk(refd, 1'b1);
        wr(16'h02F2, 16'h11C0, 1'b1);
        chk({13'h0000, adc_offset_trim_step}, 16'h0005);
        rd(16'h02F2, 1'b1, 16'h1BC0);
        chk(sleep_ref_trim_step, 3'h3);
        $display("test lock done");
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        #1;
        chk(sleep_ref_trim_frozen, 1'b0);
        rd(16'h02F2, 1'b1, 16'h0000);
        wr(16'h02F1, 16'hFFF7, 1'b1);
        chk(sleep_ref_trim_step, 3'h0);
        chk(sleep_ref_trim_active, 1'b1);
        rd(16'h02F1, 1'b1, 16'h0017);
        wr(16'h03F3, 16'hA5FF, 1'b1);
        chk({13'h0000, adc_offset_trim_step}, 16'h0002);
        chk({spare_trim_enable, spare_trim_code}, 4'h5);
        rd(16'h03F3, 1'b1, 16'hA500);
        $display("test mid_reset done");
        summarize();
    end
endmodule

/* File: verification/trim_bank_chk.sv */
/*
 Port assertions for the analog trim register bank.
 Assumes one-cycle request pulses and answers one edge later.
*/
`timescale 1ns/100ps
module trim_bank_chk
    import trim_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_word,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_ack,
    input wire logic bus_write_refused,
    input wire logic [2:0] sleep_ref_trim_step,
    input wire logic sleep_ref_trim_active,
    input wire logic sleep_ref_trim_frozen,
    input wire logic signed [2:0] adc_offset_trim_step,
    input wire logic adc_offset_trim_active,
    input wire logic spare_trim_enable,
    input wire logic [2:0] spare_trim_code
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire in_bank = bus_addr[15:8] == 8'h02 || bus_addr[15:8] == 8'h03;
    // Next cycle quiet so the stored byte is not overwritten before it shows
    sequence s_adc_wr;
        bus_wr && !bus_word && in_bank && bus_addr[7:0] == ADC_TRIM_OFFSET ##1 !bus_wr;
    endsequence
    property p_ack; (bus_wr || bus_rd) |=> bus_ack; endproperty
    property p_refuse; bus_write_refused |-> $past(bus_wr) && sleep_ref_trim_frozen; endproperty
    property p_frozen_hold; sleep_ref_trim_frozen |=> sleep_ref_trim_frozen; endproperty
    property p_sleep_off; !sleep_ref_trim_active |-> sleep_ref_trim_step == 3'h0; endproperty
    property p_adc_off; !adc_offset_trim_active |-> adc_offset_trim_step == 3'sh0; endproperty
    property p_step_range; sleep_ref_trim_step != 3'h7; endproperty
    property p_frozen_stable;
        sleep_ref_trim_frozen && $past(sleep_ref_trim_frozen, 2)
            |-> $stable(sleep_ref_trim_step) && sleep_ref_trim_active;
    endproperty
    property p_unmapped;
        bus_rd && !bus_word && in_bank && bus_addr[7:0] < SLEEP_TRIM_OFFSET
            |=> bus_rdata == 16'h0000;
    endproperty
    property p_spare;
        s_adc_wr |=> spare_trim_code == $past(bus_wdata[2:0], 2)
            && spare_trim_enable == $past(bus_wdata[3], 2);
    endproperty
    a_ack: assert property (p_ack) else $error("request not acked");
    a_refuse: assert property (p_refuse) else $error("refusal without frozen write");
    a_frozen_hold: assert property (p_frozen_hold) else $error("freeze lost");
    a_sleep_off: assert property (p_sleep_off) else $error("sleep trim while off");
    a_adc_off: assert property (p_adc_off) else $error("adc trim while off");
    a_step_range: assert property (p_step_range) else $error("sleep step 7");
    a_frozen_stable: assert property (p_frozen_stable) else $error("frozen step moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_spare: assert property (p_spare) else $error("spare bits differ");
endmodule

bind analog_trim_register_bank trim_bank_chk trim_bank_chk_inst (.*);
